// ---- hw/clock_divisor_map.vh ----
/*
 * register map and field layout of the clock divisor control block.
 * assumes a 32-bit classic wishbone slave with word-aligned byte addresses.
 */
`ifndef CLOCK_DIVISOR_MAP_VH
`define CLOCK_DIVISOR_MAP_VH

// byte offsets
`define CDC_CTRL_OFFSET    8'h00
`define CDC_STATUS_OFFSET  8'h04

// control register fields
`define CDC_RECOVER_BIT    15
`define CDC_RATIO_MSB      14
`define CDC_RATIO_LSB      12
`define CDC_REDUCE_EN_BIT  11
`define CDC_RCDIV_MSB      10
`define CDC_RCDIV_LSB      8
`define CDC_POST_MSB       7
`define CDC_POST_LSB       6
`define CDC_UNUSED_BIT     5
`define CDC_PRE_MSB        4
`define CDC_PRE_LSB        0

// control register reset value and writable bit mask
`define CDC_CTRL_RESET     16'h3040
`define CDC_CTRL_WMASK     16'hFFDF

// pll output divider codes
`define CDC_POST_DIV2      2'h0
`define CDC_POST_DIV4      2'h1
`define CDC_POST_RSVD      2'h2
`define CDC_POST_DIV8      2'h3

// divider count width, wide enough for a divisor of 256
`define CDC_DIV_W          9

`endif

// ---- hw/clock_divider.v ----
/*
 * one-cycle enable divider: passes every n-th input tick as an output tick.
 * assumes a synchronised active-low reset and a divisor of at least 1.
 */
`timescale 1ns/1ps
module clock_divider #(
   parameter W = 9
) (
   // clock and reset
   input  wire         clk_i,
   input  wire         rst_n_i,
   // source tick and divisor
   input  wire         tick_i,
   input  wire [W-1:0] div_i,
   // divided tick
   output reg          tick_o
);

   reg  [W-1:0] count;
   wire [W-1:0] last;
   wire         wrap;

   assign last = div_i - {{(W-1){1'b0}}, 1'b1};
   // a divisor shrunk below the running count wraps at once instead of running to the top
   assign wrap = (count >= last);

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count  <= {W{1'b0}};
         tick_o <= 1'b0;
      end else begin
         tick_o <= tick_i & wrap;
         if (tick_i) begin
            if (wrap) begin
               count <= {W{1'b0}};
            end else begin
               count <= count + {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

endmodule

// ---- hw/clock_divisor_control.v ----
/*
 * clock divisor control register with its peripheral, rc and pll dividers,
 * reached over a classic wishbone slave.
 * assumes one clock clk_i; the rc oscillator and pll reference/output arrive
 * as one-cycle enable ticks on this clock; irq_i pulses on any interrupt.
 */
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`include "clock_divisor_map.vh"
module clock_divisor_control #(
   parameter ADR_W = 8
) (
   // clock and reset
   input  wire             clk_i,
   input  wire             nrst_i,
   // wishbone slave
   input  wire             cyc_i,
   input  wire             stb_i,
   input  wire             we_i,
   input  wire [ADR_W-1:0] adr_i,
   input  wire [3:0]       sel_i,
   input  wire [31:0]      dat_i,
   output reg  [31:0]      dat_o,
   output reg              ack_o,
   // source ticks and interrupt event
   input  wire             irq_i,
   input  wire             rc_tick_i,
   input  wire             pll_ref_tick_i,
   input  wire             pll_out_tick_i,
   // divided ticks
   output wire             periph_tick_o,
   output wire             rc_div_tick_o,
   output wire             pll_ref_div_tick_o,
   output wire             pll_out_div_tick_o,
   // live control levels
   output reg              reduction_active_o
);

   localparam W = `CDC_DIV_W;

   // reset release through two flip-flops
   reg rst_meta;
   reg rst_n;

   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // power-of-two divisor from a three-bit code
   function [W-1:0] pow2_div;
      input [2:0] code;
      begin
         pow2_div = {{(W-1){1'b0}}, 1'b1} << code;
      end
   endfunction

   // rc postscaler: top code jumps to 256
   function [W-1:0] rc_div;
      input [2:0] code;
      begin
         if (code == 3'h7) begin
            rc_div = 9'h100;
         end else begin
            rc_div = pow2_div(code);
         end
      end
   endfunction

   // pll output divider; the reserved code holds the default ratio
   function [W-1:0] post_div;
      input [1:0] code;
      begin
         case (code)
            `CDC_POST_DIV2: post_div = 9'h002;
            `CDC_POST_DIV4: post_div = 9'h004;
            `CDC_POST_DIV8: post_div = 9'h008;
            default:        post_div = 9'h004;
         endcase
      end
   endfunction

   // byte-lane merge of a write into a 16-bit register
   function [15:0] lane_merge;
      input [15:0] old;
      input [15:0] wr;
      input [1:0]  sel;
      begin
         lane_merge[7:0]  = sel[0] ? wr[7:0]  : old[7:0];
         lane_merge[15:8] = sel[1] ? wr[15:8] : old[15:8];
      end
   endfunction

   // control register
   reg  [15:0] ctrl;
   reg  [15:0] next_ctrl;
   // sticky flag: reserved pll output code was written
   reg         rsvd_seen;
   reg         next_rsvd_seen;

   wire        req;
   wire        hit_ctrl;
   wire        hit_status;
   wire        wr_ctrl;
   wire [15:0] merged;

   assign req        = cyc_i & stb_i & ~ack_o;
   assign hit_ctrl   = (adr_i == `CDC_CTRL_OFFSET);
   assign hit_status = (adr_i == `CDC_STATUS_OFFSET);
   assign wr_ctrl    = req & we_i & hit_ctrl;
   assign merged     = lane_merge(ctrl, dat_i[15:0], sel_i[1:0]);

   wire        recover = ctrl[`CDC_RECOVER_BIT];
   wire [2:0]  ratio   = ctrl[`CDC_RATIO_MSB:`CDC_RATIO_LSB];
   wire        reduce  = ctrl[`CDC_REDUCE_EN_BIT];
   wire [2:0]  rcdiv   = ctrl[`CDC_RCDIV_MSB:`CDC_RCDIV_LSB];
   wire [1:0]  post    = ctrl[`CDC_POST_MSB:`CDC_POST_LSB];
   wire [4:0]  pre     = ctrl[`CDC_PRE_MSB:`CDC_PRE_LSB];

   always @* begin
      next_ctrl      = ctrl;
      next_rsvd_seen = rsvd_seen;
      if (wr_ctrl) begin
         next_ctrl = merged & `CDC_CTRL_WMASK;
         if (sel_i[0] && merged[`CDC_POST_MSB:`CDC_POST_LSB] == `CDC_POST_RSVD) begin
            next_rsvd_seen = 1'b1;
         end
      end
      // interrupt recovery wins over a write in the same cycle
      if (irq_i && recover) begin
         next_ctrl[`CDC_REDUCE_EN_BIT] = 1'b0;
      end
      if (req && !we_i && hit_status) begin
         next_rsvd_seen = 1'b0;
      end
   end

   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctrl      <= `CDC_CTRL_RESET;
         rsvd_seen <= 1'b0;
      end else begin
         ctrl      <= next_ctrl;
         rsvd_seen <= next_rsvd_seen;
      end
   end

   // effective peripheral divisor
   wire [W-1:0] periph_div;
   assign periph_div = reduce ? pow2_div(ratio) : {{(W-1){1'b0}}, 1'b1};

   // wishbone answer one cycle after the request, read data registered
   reg [31:0] next_dat;

   always @* begin
      next_dat = 32'h0000_0000;
      if (hit_ctrl) begin
         next_dat = {16'h0000, ctrl};
      end else if (hit_status) begin
         next_dat = {7'h00, rsvd_seen, 7'h00, periph_div, 8'h00};
      end
   end

   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ack_o              <= 1'b0;
         dat_o              <= 32'h0000_0000;
         reduction_active_o <= 1'b0;
      end else begin
         ack_o              <= req;
         reduction_active_o <= next_ctrl[`CDC_REDUCE_EN_BIT];
         if (req && !we_i) begin
            dat_o <= next_dat;
         end else begin
            dat_o <= 32'h0000_0000;
         end
      end
   end

   // peripheral clock from the instruction clock
   clock_divider #(.W(W)) u_periph (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .tick_i  (1'b1),
      .div_i   (periph_div),
      .tick_o  (periph_tick_o)
   );

   // rc oscillator postscaler
   clock_divider #(.W(W)) u_rc (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .tick_i  (rc_tick_i),
      .div_i   (rc_div(rcdiv)),
      .tick_o  (rc_div_tick_o)
   );

   // pll input prescaler: code plus two
   clock_divider #(.W(W)) u_pre (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .tick_i  (pll_ref_tick_i),
      .div_i   ({4'h0, pre} + 9'h002),
      .tick_o  (pll_ref_div_tick_o)
   );

   // pll output postscaler
   clock_divider #(.W(W)) u_post (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .tick_i  (pll_out_tick_i),
      .div_i   (post_div(post)),
      .tick_o  (pll_out_div_tick_o)
   );

endmodule

// ---- verif/clock_divisor_control_asserts.sv ----
/* port-level checks of the clock divisor control block.
   assumes bench ticks and a shadow of control bits 15:8 kept from writes as the block takes them. */
`timescale 1ns/1ps
module clock_divisor_control_asserts (
   // clock, reset, bus
   input wire        clk_i, nrst_i, cyc_i, stb_i, we_i,
   input wire [7:0]  adr_i,
   input wire [3:0]  sel_i,
   input wire [31:0] dat_i, dat_o,
   input wire        ack_o,
   // ticks and levels
   input wire        irq_i, rc_tick_i, pll_ref_tick_i, pll_out_tick_i, periph_tick_o,
   input wire        rc_div_tick_o, pll_ref_div_tick_o, pll_out_div_tick_o, reduction_active_o
);
   reg [2:0] up;
   reg [7:0] sh;
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         up <= 3'h0;
         sh <= 8'h30;
      end else begin
         if (up != 3'h7) up <= up + 3'h1;
         if (cyc_i && stb_i && we_i && !ack_o && adr_i == 8'h00 && sel_i[1]) sh <= dat_i[15:8];
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
   chk_ack_answer: assert property (cyc_i && stb_i && !ack_o && up == 3'h7 |=> ack_o) else $error("no ack");
   chk_read_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("data outside ack");
   chk_ctrl_read: assert property (cyc_i && stb_i && !we_i && !ack_o && adr_i == 8'h00
      |=> dat_o[31:16] == 16'h0 && !dat_o[5]) else $error("unused control bits set");
   chk_roi_clear: assert property (irq_i && sh[7] |-> ##[1:3] !reduction_active_o)
      else $error("interrupt kept reduction");
   chk_reduce_off: assert property (up == 3'h7 && !reduction_active_o && !$past(reduction_active_o)
      && !$past(reduction_active_o, 2) |-> periph_tick_o) else $error("peripheral tick not 1:1");
   chk_rc_unity: assert property (up == 3'h7 && sh[2:0] == 3'h0 && rc_tick_i |=> rc_div_tick_o)
      else $error("rc divide by 1 lost tick");
   chk_ref_cause: assert property (pll_ref_div_tick_o |-> $past(pll_ref_tick_i))
      else $error("reference tick without source");
   chk_ref_min: assert property (pll_ref_div_tick_o |=> !pll_ref_div_tick_o) else $error("ref below 2");
   chk_out_min: assert property (pll_out_div_tick_o |=> !pll_out_div_tick_o) else $error("post below 2");
endmodule
bind clock_divisor_control clock_divisor_control_asserts chk_u (.clk_i, .nrst_i, .cyc_i, .stb_i, .we_i,
   .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .irq_i, .rc_tick_i, .pll_ref_tick_i, .pll_out_tick_i,
   .periph_tick_o, .rc_div_tick_o, .pll_ref_div_tick_o, .pll_out_div_tick_o, .reduction_active_o);

// ---- verif/test_clock_divisor_control.sv ----
/* self-checking bench of the clock divisor control block.
   assumes one clock; the three source ticks run every cycle after reset. */
`timescale 1ns/1ps
module test_clock_divisor_control;
   reg         clk_i = 0, nrst_i = 0, cyc_i = 0, stb_i = 0, we_i = 0, irq_i = 0, tk = 0;
   reg  [7:0]  adr_i = 8'h00;
   reg  [3:0]  sel_i = 4'h0;
   reg  [31:0] dat_i = 32'h0, r;
   reg  [15:0] v;
   reg  [2:0]  c;
   wire [31:0] dat_o;
   wire        ack_o, reduction_active_o;
   wire [3:0]  outs;
   integer     n_mismatch = 0, checks_done = 0, i;
   always #2 clk_i = ~clk_i;
   clock_divisor_control dut_u (.clk_i, .nrst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
      .ack_o, .irq_i, .rc_tick_i(tk), .pll_ref_tick_i(tk), .pll_out_tick_i(tk), .periph_tick_o(outs[0]),
      .rc_div_tick_o(outs[1]), .pll_ref_div_tick_o(outs[2]), .pll_out_div_tick_o(outs[3]),
      .reduction_active_o);
   function [31:0] e_rc(input [2:0] k);
      e_rc = (k == 3'h7) ? 256 : (1 << k);
   endfunction
   function [31:0] e_post(input [1:0] k);
      e_post = (k == 2'h0) ? 2 : (k == 2'h3) ? 8 : 4;
   endfunction
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task test_done;
      begin
         if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   task wb(input w, input [7:0] a, input [15:0] d, input [3:0] s);
      begin
         @(posedge clk_i);
         {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, 16'h0, d, s};
         @(posedge clk_i);
         while (ack_o !== 1'b1) @(posedge clk_i);
         r = dat_o;
         {cyc_i, stb_i} <= 2'h0;
      end
   endtask
   task meas(input integer o, input [31:0] e);
      integer n;
      begin
         for (n = 0; n < 600 && outs[o] !== 1'b1; n = n + 1) @(posedge clk_i);
         n = 0;
         do begin
            @(posedge clk_i);
            n = n + 1;
         end while (outs[o] !== 1'b1 && n < 600);
         chk(n, e);
      end
   endtask
   task cfg;
      begin
         wb(1, 8'h00, v, 4'h3);
         wb(0, 8'h00, 16'h0, 4'h3);
         chk(r, {16'h0, v & 16'hFFDF});
         meas(0, v[11] ? (1 << v[14:12]) : 1);
         meas(1, e_rc(v[10:8]));
         meas(2, v[4:0] + 2);
         meas(3, e_post(v[7:6]));
      end
   endtask
   initial begin
      r = $urandom(13449);
      repeat (3) @(posedge clk_i);
      nrst_i <= 1;
      tk <= 1;
      repeat (3) @(posedge clk_i);
      wb(0, 8'h00, 16'h0, 4'h3);
      chk(r, 32'h3040);
      wb(0, 8'h08, 16'h0, 4'h3);
      chk(r, 32'h0);
      wb(1, 8'h00, 16'hFFFF, 4'h1);
      wb(0, 8'h00, 16'h0, 4'h3);
      chk(r, 32'h30DF);
      for (i = 0; i < 20; i = i + 1) begin
         c = i[2:0];
         v = {1'b0, c, c[0], c, c[1:0], 1'b1, (c == 3'h7) ? 5'h1F : {2'h0, c}};
         if (i > 7) begin
            r = $urandom;
            v = r[15:0];
         end
         cfg;
      end
      // ratio 110 enabled with the reserved output code, then the status view
      v = 16'h6880;
      cfg;
      wb(0, 8'h04, 16'h0, 4'h3);
      chk(r, 32'h0100_4000);
      wb(0, 8'h04, 16'h0, 4'h3);
      chk(r, 32'h0000_4000);
      wb(1, 8'h04, 16'hFFFF, 4'h3);
      wb(0, 8'h00, 16'h0, 4'h3);
      chk(r, 32'h0000_6880);
      for (i = 0; i < 2; i = i + 1) begin
         v = i ? 16'h0840 : 16'h8840;
         wb(1, 8'h00, v, 4'h3);
         repeat (2) @(posedge clk_i);
         chk(reduction_active_o, 1'b1);
         irq_i <= 1;
         @(posedge clk_i);
         irq_i <= 0;
         repeat (3) @(posedge clk_i);
         chk(reduction_active_o, i);
         wb(0, 8'h00, 16'h0, 4'h3);
         chk(r, i ? 32'h0840 : 32'h8040);
      end
      test_done;
   end
   initial begin
      #120000;
      n_mismatch = n_mismatch + 1;
      test_done;
   end
endmodule
